//--- bench/msi_host_model.sv
`timescale 1ns/1ps
// ************************************************************
// host port and external switches
// ************************************************************
module msi_host_model (
    input wire logic ref_clk,
    input wire logic pump_run,
    input wire logic stop_req,
    input wire logic fault_req,
    input wire logic toff_req,
    output logic estop_in,
    output logic trouble_n_in,
    output logic torque_off_n_in,
    output logic pump_line_in
);
    logic [1:0] div_q = 2'h0;
    initial pump_line_in = 1'b0;
    // stop pin grounded unless a stop is requested
    assign estop_in = stop_req;
    // released pins are pulled up
    assign trouble_n_in = ~fault_req;
    assign torque_off_n_in = ~toff_req;
    // toggles while software runs, holds its level once it stops
    always @(posedge ref_clk) begin
        div_q <= div_q + 2'h1;
        if (pump_run && div_q[0]) begin
            pump_line_in <= ~pump_line_in;
        end
    end
endmodule // msi_host_model

//--- bench/tb.sv
`timescale 1ns/1ps
module tb;
    localparam int WDOG = 16;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic pump_run = 1'b0, stop_req = 1'b0, fault_req = 1'b0, toff_req = 1'b0;
    logic estop_in, trouble_n_in, torque_off_n_in, pump_line_in;
    logic [3:0] drive_alarm_in = 4'h0;
    logic pump_gate_jumper = 1'b0;
    logic [7:0] host_data_in = 8'ha5;
    logic [3:0] host_ctrl_in = 4'hf;
    logic [1:0] relay_sel_in = 2'h3;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic [31:0] reg_rdata, rd_val;
    logic [7:0] stepdir_out, stepdir_oe;
    logic [3:0] ctrl_out, ctrl_oe;
    logic [1:0] relay_drive;
    logic outputs_on_lamp, chain_out, chain_oe, host_status_out, motor_current_low;
    int n_fail = 0;
    int cmp_count = 0;
    int n;
    msi_host_model host (.ref_clk(ref_clk), .pump_run(pump_run), .stop_req(stop_req), .fault_req(fault_req),
        .toff_req(toff_req), .estop_in(estop_in), .trouble_n_in(trouble_n_in),
        .torque_off_n_in(torque_off_n_in), .pump_line_in(pump_line_in));
    msi_core #(.WDOG_TIMEOUT(WDOG)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
        .estop_in(estop_in), .trouble_n_in(trouble_n_in), .torque_off_n_in(torque_off_n_in),
        .drive_alarm_in(drive_alarm_in), .pump_line_in(pump_line_in), .pump_gate_jumper(pump_gate_jumper),
        .host_data_in(host_data_in), .host_ctrl_in(host_ctrl_in), .relay_sel_in(relay_sel_in),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .stepdir_out(stepdir_out), .stepdir_oe(stepdir_oe), .ctrl_out(ctrl_out), .ctrl_oe(ctrl_oe),
        .relay_drive(relay_drive), .outputs_on_lamp(outputs_on_lamp), .chain_out(chain_out),
        .chain_oe(chain_oe), .host_status_out(host_status_out), .motor_current_low(motor_current_low));
    // ************************************************************
    // clock and run limit
    // ************************************************************
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        close_out();
    end
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic close_out();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
        @(negedge ref_clk);
        check("rdata_idle", reg_rdata, 32'h0);
    endtask
    task automatic settle();
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic check_state(input logic en, input logic st, input logic mcl);
        check("stepdir_oe", stepdir_oe, en ? 8'hff : 8'h00);
        if (en) check("stepdir_out", stepdir_out, host_data_in);
        check("ctrl_oe", ctrl_oe, en ? 4'hf : 4'h0);
        if (en) check("ctrl_out", ctrl_out, host_ctrl_in);
        check("chain_out", chain_out, 1'b1);
        check("relay_drive", relay_drive, en ? (host_ctrl_in[1:0] & relay_sel_in) : 2'h0);
        check("outputs_on_lamp", outputs_on_lamp, en);
        check("chain_oe", chain_oe, en);
        check("host_status_out", host_status_out, st);
        check("motor_current_low", motor_current_low, mcl);
    endtask
    task automatic wait_lamp(input logic v, output int cnt);
        cnt = 0;
        while (outputs_on_lamp !== v && cnt < 80) begin
            @(negedge ref_clk);
            cnt++;
        end
        if (cnt >= 80) begin
            n_fail++;
            close_out();
        end
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        settle();
        reg_write(msi_pkg::REG_EVENTS, 32'hf);
        settle();
        check_state(1'b1, 1'b0, 1'b0);
        reg_read(msi_pkg::REG_STATUS, rd_val);
        check("status", rd_val[5:0], 6'h01);
        reg_read(4'hc, rd_val);
        check("unmapped", rd_val, 32'h0);
        // each interlock source alone, then released
        for (int m = 0; m < 7; m++) begin
            @(posedge ref_clk);
            stop_req <= (m == 0);
            fault_req <= (m == 1);
            toff_req <= (m == 2);
            drive_alarm_in <= (m > 2) ? (4'h1 << (m - 3)) : 4'h0;
            settle();
            check_state(1'b0, 1'b1, m == 2);
            @(posedge ref_clk);
            stop_req <= 1'b0;
            fault_req <= 1'b0;
            toff_req <= 1'b0;
            drive_alarm_in <= 4'h0;
            settle();
            check_state(1'b1, 1'b0, 1'b0);
        end
        reg_read(msi_pkg::REG_EVENTS, rd_val);
        check("events", rd_val[2:0], 3'h7);
        reg_write(msi_pkg::REG_EVENTS, 32'h7);
        reg_read(msi_pkg::REG_EVENTS, rd_val);
        check("events_clr", rd_val[2:0], 3'h0);
        reg_write(msi_pkg::REG_CONFIG, 32'h2);
        settle();
        check("forced_lamp", outputs_on_lamp, 1'b0);
        reg_write(msi_pkg::REG_CONFIG, 32'h0);
        settle();
        check("released_lamp", outputs_on_lamp, 1'b1);
        // clock enable low freezes the interlock path
        @(posedge ref_clk);
        clk_en <= 1'b0;
        stop_req <= 1'b1;
        settle();
        check("frozen_lamp", outputs_on_lamp, 1'b1);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        settle();
        check("thawed_lamp", outputs_on_lamp, 1'b0);
        @(posedge ref_clk);
        stop_req <= 1'b0;
        settle();
        check("restart_lamp", outputs_on_lamp, 1'b1);
        // gating selected with no toggling yet
        @(posedge ref_clk);
        pump_gate_jumper <= 1'b1;
        host_ctrl_in <= 4'h2;
        relay_sel_in <= 2'h2;
        settle();
        check_state(1'b0, 1'b0, 1'b0);
        @(posedge ref_clk);
        pump_run <= 1'b1;
        wait_lamp(1'b1, n);
        settle();
        check_state(1'b1, 1'b0, 1'b0);
        @(posedge ref_clk);
        pump_run <= 1'b0;
        wait_lamp(1'b0, n);
        check("wdog_delay", n >= WDOG, 1'b1);
        settle();
        check_state(1'b0, 1'b0, 1'b0);
        close_out();
    end
endmodule // tb

//--- design/msi_core.sv
`timescale 1ns/1ps
// Summary of operation
// [R1] Trouble input low means fault; high or floating means normal.
// [R2] Emergency-stop high means stop; an undriven input defaults to stop.
// [R3] Torque-off is active low; unconnected means not asserted.
// [R4] Stop, trouble and torque-off are ORed to drive status and gate buffers.
// [R5] Every drive alarm joins the trouble condition.
// [R6] Status line high while any interlock asserted, low otherwise.
// [R7] Step and direction outputs float while interlocked.
// [R8] Control outputs float while interlocked; pull-down gives low.
// [R9] Both relays de-energized while interlocked, regardless of host level.
// [R10] Outputs-on lamp lit only while outputs are enabled.
// [R11] Chain output floats with weak pull-down while interlocked.
// [R12] Only torque-off reduces motor current.
// [R13] Torque-off also gives the full stop response.
// [R14] Watchdog healthy while monitored line toggles, failed when toggling stops.
// [R15] Watchdog failure gates outputs only with pump-gating jumper setting; the code also gates on config bit CFG_BIT_SW_GATE.
// [R16] Watchdog state never affects the status line.
// [R17] With gating selected outputs stay disabled from power-up until toggling starts.
// [R18] Host toggles the monitored line continuously, or gating is disabled.
// [R19] External side grounds emergency-stop in normal operation.
// [R20] Watchdog fails after a parameter count of idle cycles, recovers on edges.
module msi_core #(
    parameter int AXES = msi_pkg::AXIS_COUNT,
    parameter int DATA_W = msi_pkg::DATA_WIDTH,
    parameter int CTRL_W = msi_pkg::CTRL_WIDTH,
    parameter int RELAYS = msi_pkg::RELAY_COUNT,
    parameter int WDOG_TIMEOUT = msi_pkg::WDOG_TIMEOUT_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic estop_in,
    input wire logic trouble_n_in,
    input wire logic torque_off_n_in,
    input wire logic [AXES-1:0] drive_alarm_in,
    input wire logic pump_line_in,
    input wire logic pump_gate_jumper,
    input wire logic [DATA_W-1:0] host_data_in,
    input wire logic [CTRL_W-1:0] host_ctrl_in,
    input wire logic [RELAYS-1:0] relay_sel_in,
    input wire logic [msi_pkg::ADDR_WIDTH-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [DATA_W-1:0] stepdir_out,
    output logic [DATA_W-1:0] stepdir_oe,
    output logic [CTRL_W-1:0] ctrl_out,
    output logic [CTRL_W-1:0] ctrl_oe,
    output logic [RELAYS-1:0] relay_drive,
    output logic outputs_on_lamp,
    output logic chain_out,
    output logic chain_oe,
    output logic host_status_out,
    output logic motor_current_low
);
    localparam int NIN = 4 + AXES;
    typedef struct packed {
        logic [1:0] cfg;
        logic [3:0] events;
        logic interlock;
        logic enable;
        logic torque_low;
        logic [DATA_W-1:0] step_data;
        logic [CTRL_W-1:0] ctrl_data;
        logic [RELAYS-1:0] relays;
        logic [31:0] rdata;
    } msi_core_s;
    msi_core_s st_q;
    msi_core_s st_d;
    logic [NIN-1:0] pins_raw;
    logic [NIN-1:0] pins_sync;
    logic [NIN-1:0] pins_safe;
    logic [DATA_W+CTRL_W+RELAYS-1:0] host_sync;
    logic estop_s;
    logic trouble_n_s;
    logic torque_off_n_s;
    logic jumper_s;
    logic [AXES-1:0] alarm_s;
    logic wdog_ok;
    logic trouble;
    logic torque_off;
    logic interlock;
    logic gate_pump;
    logic enable;
    initial begin
        if (AXES < 1 || AXES > 16 || DATA_W < 1 || CTRL_W < 1 || RELAYS < 1 || RELAYS > CTRL_W) begin
            $error("msi_core parameters out of range");
        end
    end
    // ************************************************************
    // input synchronisers; safe values hold stop state until first sample
    // ************************************************************
    assign pins_raw = {pump_gate_jumper, drive_alarm_in, torque_off_n_in, trouble_n_in, estop_in};
    assign pins_safe = {1'b1, {AXES{1'b1}}, 1'b1, 1'b0, 1'b1};
    msi_sync #(.WIDTH(NIN)) u_pin_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .async_in(pins_raw),
        .reset_val(pins_safe),
        .sync_out(pins_sync)
    );
    msi_sync #(.WIDTH(DATA_W + CTRL_W + RELAYS)) u_host_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .async_in({relay_sel_in, host_ctrl_in, host_data_in}),
        .reset_val('0),
        .sync_out(host_sync)
    );
    msi_wdog #(.TIMEOUT_CYCLES(WDOG_TIMEOUT)) u_wdog (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .pulse_in(pump_line_in),
        .healthy(wdog_ok)
    );
    assign estop_s = pins_sync[0];
    assign trouble_n_s = pins_sync[1];
    assign torque_off_n_s = pins_sync[2];
    assign alarm_s = pins_sync[3 +: AXES];
    assign jumper_s = pins_sync[NIN-1];
    // ************************************************************
    // interlock combination
    // ************************************************************
    assign trouble = !trouble_n_s || (|alarm_s); // R1 R5
    assign torque_off = !torque_off_n_s; // R3 R13
    assign interlock = estop_s || trouble || torque_off; // R2 R4 R19
    assign gate_pump = (jumper_s || st_q.cfg[msi_pkg::CFG_BIT_SW_GATE]) && !wdog_ok; // R15 R17 R18
    assign enable = !interlock && !gate_pump && !st_q.cfg[msi_pkg::CFG_BIT_SW_FORCE];
    // ************************************************************
    // state update and register port
    // ************************************************************
    always_comb begin
        st_d = st_q;
        if (clk_en) begin
            st_d.interlock = interlock; // R6 R16
            st_d.enable = enable;
            st_d.torque_low = torque_off; // R12
            st_d.step_data = host_sync[DATA_W-1:0];
            st_d.ctrl_data = host_sync[DATA_W +: CTRL_W];
            st_d.relays = enable ? (host_sync[DATA_W+CTRL_W +: RELAYS] & host_sync[DATA_W +: RELAYS]) : '0; // R9
            st_d.events = st_q.events;
            if (reg_wr && reg_addr == msi_pkg::REG_EVENTS) begin
                st_d.events = st_q.events & ~reg_wdata[3:0];
            end
            if (estop_s) begin
                st_d.events[0] = 1'b1;
            end
            if (trouble) begin
                st_d.events[1] = 1'b1;
            end
            if (torque_off) begin
                st_d.events[2] = 1'b1;
            end
            if (gate_pump) begin
                st_d.events[3] = 1'b1;
            end
            if (reg_wr && reg_addr == msi_pkg::REG_CONFIG) begin
                st_d.cfg = reg_wdata[1:0];
            end
            st_d.rdata = '0;
            if (reg_rd) begin
                case (reg_addr)
                    msi_pkg::REG_CONFIG: st_d.rdata = {30'h0, st_q.cfg};
                    msi_pkg::REG_STATUS: st_d.rdata = {26'h0, jumper_s, wdog_ok, torque_off, trouble, estop_s,
                        st_q.enable};
                    msi_pkg::REG_EVENTS: st_d.rdata = {28'h0, st_q.events};
                    default: st_d.rdata = '0;
                endcase
            end
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.interlock <= 1'b1;
            st_q.cfg <= msi_pkg::CONFIG_RESET;
        end else begin
            st_q <= st_d;
        end
    end
    // ************************************************************
    // output drivers
    // ************************************************************
    assign reg_rdata = st_q.rdata;
    assign host_status_out = st_q.interlock; // R6 R16
    assign stepdir_out = st_q.step_data;
    assign stepdir_oe = {DATA_W{st_q.enable}}; // R7
    assign ctrl_out = st_q.ctrl_data;
    assign ctrl_oe = {CTRL_W{st_q.enable}}; // R8 R13
    assign relay_drive = st_q.relays; // R9
    assign outputs_on_lamp = st_q.enable; // R10
    assign chain_out = 1'b1;
    assign chain_oe = st_q.enable; // R11
    assign motor_current_low = st_q.torque_low; // R12
    // ************************************************************
    // checks
    // ************************************************************
    AST_STATUS_FOLLOWS: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en |=> host_status_out == $past(interlock)) else $error("status line mismatch"); // R6
    AST_STEP_FLOAT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (clk_en && interlock) |=> stepdir_oe == '0) else $error("step outputs driven in interlock"); // R7
    AST_CTRL_FLOAT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (clk_en && interlock) |=> ctrl_oe == '0) else $error("control outputs driven in interlock"); // R8
    AST_RELAY_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (clk_en && interlock) |=> relay_drive == '0) else $error("relay energized in interlock"); // R9
    AST_LAMP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        outputs_on_lamp == stepdir_oe[0] && outputs_on_lamp == chain_oe) else $error("lamp mismatch"); // R10
    AST_CHAIN: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (clk_en && trouble) |=> !chain_oe) else $error("chain driven during trouble"); // R11
    AST_CURRENT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (clk_en && estop_s && torque_off_n_s) |=> !motor_current_low) else $error("current cut by stop"); // R12
    AST_TORQUE_STOP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (clk_en && torque_off) |=> (motor_current_low && !stepdir_oe[0] && host_status_out))
        else $error("torque-off without full stop"); // R13
    AST_PUMP_GATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (clk_en && jumper_s && !wdog_ok) |=> !outputs_on_lamp) else $error("pump failure not gating"); // R15
    AST_PUMP_STATUS: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (clk_en && !wdog_ok && !interlock) |=> !host_status_out) else $error("watchdog on status line"); // R16
    AST_ALARM: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (clk_en && (|alarm_s)) |=> host_status_out) else $error("drive alarm ignored"); // R5
endmodule // msi_core

//--- design/msi_pkg.sv
package msi_pkg;
    // ************************************************************
    // widths and counts
    // ************************************************************
    localparam int AXIS_COUNT = 4;
    localparam int DATA_WIDTH = 8;
    localparam int CTRL_WIDTH = 4;
    localparam int RELAY_COUNT = 2;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_FREQ_HZ = 10000000;
    localparam int WDOG_TIMEOUT_US = 1000;
    localparam int WDOG_TIMEOUT_CYCLES = (WDOG_TIMEOUT_US * (CLK_FREQ_HZ / 1000000));
    localparam int WDOG_RESUME_EDGES = 2;
    // ************************************************************
    // register map
    // ************************************************************
    localparam int ADDR_WIDTH = 4;
    localparam logic [3:0] REG_CONFIG = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_EVENTS = 4'h8;
    localparam logic [1:0] CONFIG_RESET = 2'h0;
    localparam int CFG_BIT_SW_GATE = 0;
    localparam int CFG_BIT_SW_FORCE = 1;
endpackage

//--- design/msi_sync.sv
`timescale 1ns/1ps
module msi_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] async_in,
    input wire logic [WIDTH-1:0] reset_val,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
        logic filled;
        logic primed;
    } msi_sync_s;
    msi_sync_s st_q;
    msi_sync_s st_d;
    initial begin
        if (WIDTH < 1) begin
            $error("msi_sync width must be positive");
        end
    end
    // ************************************************************
    // two-stage synchroniser; output held at safe value until primed
    // ************************************************************
    always_comb begin
        st_d = st_q;
        if (clk_en) begin
            st_d.meta = async_in;
            st_d.stable = st_q.meta;
            st_d.filled = 1'b1;
            st_d.primed = st_q.filled;
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign sync_out = st_q.primed ? st_q.stable : reset_val;
endmodule // msi_sync

//--- design/msi_wdog.sv
`timescale 1ns/1ps
module msi_wdog #(
    parameter int TIMEOUT_CYCLES = msi_pkg::WDOG_TIMEOUT_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic pulse_in,
    output logic healthy
);
    localparam int CW = $clog2(TIMEOUT_CYCLES + 1);
    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
        logic [CW-1:0] idle_cnt;
        logic [1:0] edge_cnt;
        logic ok;
    } msi_wdog_s;
    msi_wdog_s st_q;
    msi_wdog_s st_d;
    initial begin
        if (TIMEOUT_CYCLES < 2) begin
            $error("watchdog timeout must be at least two cycles");
        end
    end
    // ************************************************************
    // edge watch: failure after timeout with no edge, healthy after edges resume
    // ************************************************************
    always_comb begin
        st_d = st_q;
        if (clk_en) begin
            st_d.meta = pulse_in;
            st_d.sync = st_q.meta;
            st_d.last = st_q.sync;
            if (st_q.sync != st_q.last) begin
                st_d.idle_cnt = '0; // R20
                if (!st_q.ok) begin
                    if (st_q.edge_cnt == 2'(msi_pkg::WDOG_RESUME_EDGES - 1)) begin
                        st_d.ok = 1'b1; // R14
                        st_d.edge_cnt = '0;
                    end else begin
                        st_d.edge_cnt = st_q.edge_cnt + 2'h1;
                    end
                end
            end else if (st_q.idle_cnt == CW'(TIMEOUT_CYCLES - 1)) begin
                st_d.ok = 1'b0; // R14
                st_d.edge_cnt = '0;
            end else begin
                st_d.idle_cnt = st_q.idle_cnt + CW'(1);
            end
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign healthy = st_q.ok;
    AST_WDOG_TIMEOUT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (clk_en && st_q.ok && st_q.idle_cnt == CW'(TIMEOUT_CYCLES - 1) && st_q.sync == st_q.last)
        |=> !healthy) else $error("watchdog missed timeout"); // R20
endmodule // msi_wdog
